/* hdl/mrc_pkg.sv */
/*
  Constants for the multi-source reset controller: register map, field
  positions, reset values, tick counts and flow states.
  Assumes a 200 MHz aclk and an input clock derived from it by division.
*/
package mrc_pkg;

  // ********************************************************************
  // Clock rates and dividers
  // ********************************************************************
  localparam int ACLK_MHZ  = 200;
  localparam int INCLK_MHZ = 100;
  localparam int INCLK_DIV = ACLK_MHZ / INCLK_MHZ;

  // ********************************************************************
  // Flow lengths, in input / reference / PLL reference clock cycles
  // ********************************************************************
  localparam int POR_DLY_CYC  = 1024;
  localparam int PLL_LOCK_CYC = 6400;
  localparam int HRST_REL_CYC = 512;
  localparam int SRST_REL_CYC = 515;
  localparam int SOFT_HOLD_CYC = 515;
  localparam int CNT_W        = 13;

  // ********************************************************************
  // Register map (byte addresses)
  // ********************************************************************
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_STRAPS  = 8'h08;
  localparam logic [7:0]  OFF_CFG_SYS = 8'h0c;
  localparam logic [7:0]  OFF_CFG_DSI = 8'h10;
  localparam logic [7:0]  OFF_CFG_ACT = 8'h14;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ********************************************************************
  // Fields and reset values
  // ********************************************************************
  localparam int          CTRL_WDT_EN  = 0;
  localparam int          CTRL_BM_EN   = 1;
  localparam int          CTRL_PDIV_LSB = 8;
  localparam int          PDIV_W       = 4;
  localparam logic [3:0]  PDIV_RST     = 4'h1;
  localparam int          STAT_BUSY    = 8;
  localparam int          STAT_LOCKED  = 9;
  localparam int          SRC_POR      = 0;
  localparam int          SRC_HARD     = 1;
  localparam int          SRC_SOFT     = 2;
  localparam int          SRC_WDT      = 3;
  localparam int          SRC_BM       = 4;
  localparam int          SRC_HOST     = 5;
  localparam int          STRAP_MS     = 1;
  localparam int          STRAP_WDT    = 11;
  localparam logic [31:0] DEFAULT_CFG  = 32'h0000_0000;

  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_POR    = 6'h02,
    S_PORDLY = 6'h04,
    S_LOCK   = 6'h08,
    S_HRST   = 6'h10,
    S_SRST   = 6'h20
  } mrc_state_t;

endpackage

/* hdl/mrc_reset_ctrl.sv */
/*
  Reset controller: collects power-on, hard, soft, watchdog, bus monitor
  and host reset requests, sequences the reset outputs and open-drain
  reset pins, captures straps and applies the configuration word.
  Assumes all inputs synchronous to aclk and an AXI4-Lite master.
*/
// The address map and the AXI4-Lite slave port were decided locally.
// Overview of operation
// R1 - Power-on reset resets everything, drives both pins
// R2 - Mode, boot, ident straps set only at power-on
// R3 - Hard reset pin driven implies soft pin driven
// R4 - Hard pin open-drain, external low requests reset
// R5 - Hard reset drives pins, applies configuration word
// R6 - External soft request only while device idle
// R7 - Soft pin open-drain, external low requests reset
// R8 - Soft reset drives soft pin, keeps configuration
// R9 - Enabled watchdog expiry starts hard reset
// R10 - Enabled bus monitor expiry starts hard reset
// R11 - Host command starts soft reset sequence
// R12 - Status register records sources of last reset
// R13 - Straps, PLL, slave-port config: power-on only
// R14 - Bus config, hard pin, interface regs: not soft
// R15 - Every source resets cores, peripherals, shared bus
// R16 - Board holds power-on input sixteen cycles minimum
// R17 - Bus configuration as master or slave, selected
// R18 - Unwritten slave configuration uses default word
// R19 - Fourteen strap levels captured at power-on release
// R20 - Internal power-on ends 1024 input cycles later
// R21 - PLL locks 6400 reference cycles after that
// R22 - Hard pin released 512 cycles after lock
// R23 - Soft pin released 515 cycles after lock
// R24 - Most extensive flow wins, all sources recorded
`timescale 1ns/1ps
module mrc_reset_ctrl
  import mrc_pkg::*;
#(
  parameter int PLL_LOCK_TICKS = PLL_LOCK_CYC
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  input  wire logic [31:0]       s_axil_wdata,
  input  wire logic [3:0]        s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  output logic [31:0]            s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  input  wire logic              power_on_reset_n,
  input  wire logic              hard_reset_n_i,
  output logic                   hard_reset_n_o,
  output logic                   hard_reset_n_oe,
  input  wire logic              soft_reset_n_i,
  output logic                   soft_reset_n_o,
  output logic                   soft_reset_n_oe,
  input  wire logic              watchdog_zero,
  input  wire logic              bus_monitor_zero,
  input  wire logic              host_reset_cmd,
  input  wire logic              reset_cfg_mode_sel,
  input  wire logic              cfg_master_slave_sel,
  input  wire logic              slave_port_sync_sel,
  input  wire logic              slave_port_width_sel,
  input  wire logic [3:0]        device_ident_bits,
  input  wire logic [2:0]        boot_select_bits,
  input  wire logic              watchdog_enable_strap,
  input  wire logic [1:0]        clock_mode_bits,
  input  wire logic [31:0]       cfg_fetch_word,
  output logic                   internal_por,
  output logic                   system_pll_reset,
  output logic                   system_pll_locked,
  output logic                   sysif_reset,
  output logic                   periph_bus_reset,
  output logic                   core_reset,
  output logic                   shared_bus_reset,
  output logic [31:0]            active_cfg_word,
  output logic [13:0]            strap_word
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    mrc_state_t        st;
    logic [CNT_W-1:0]  cnt;
    logic [3:0]        div_in;
    logic [3:0]        div_pll;
    logic              por_flow;
    logic [13:0]       straps;
    logic              wdt_en;
    logic              bm_en;
    logic [PDIV_W-1:0] pdiv;
    logic [5:0]        status;
    logic [31:0]       cfg_word;
    logic              cfg_wr;
    logic [31:0]       cfg_act;
    logic              locked;
    logic              drv_low;
    logic              hrst_oe;
    logic              srst_oe;
    logic              int_por;
    logic              pll_rst;
    logic              awrdy;
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              wrdy;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arrdy;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } mrc_regs_t;

  mrc_regs_t s_reg;
  mrc_regs_t s_next;

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] wmerge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        r[8*i +: 8] = dat[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic at_last(
    input logic [CNT_W-1:0] c,
    input int               lim
  );
    return c == CNT_W'(lim - 1);
  endfunction

  logic             in_tick;
  logic             pll_tick;
  logic [3:0]       pdiv_m1;
  logic [5:0]       src;
  logic             hard_req;
  logic             soft_req;
  logic             new_flow;
  logic             sys_win;
  logic [31:0]      ctrl_rd;
  logic [31:0]      ctrl_w;
  logic [31:0]      stat_rd;

  always_comb
  begin
    s_next   = s_reg;
    new_flow = 1'b0;

    // ******************************************************************
    // Input clock and PLL reference tick dividers
    // ******************************************************************
    in_tick = (s_reg.div_in == 4'(INCLK_DIV - 1));
    s_next.div_in = in_tick ? 4'h0 : s_reg.div_in + 4'h1;
    pdiv_m1 = (s_reg.pdiv == 4'h0) ? 4'h0 : s_reg.pdiv - 4'h1;
    pll_tick = in_tick && (s_reg.div_pll == pdiv_m1);
    if (in_tick)
    begin
      s_next.div_pll = pll_tick ? 4'h0 : s_reg.div_pll + 4'h1;
    end

    // ******************************************************************
    // Reset sources
    // ******************************************************************
    src = 6'h00;
    src[SRC_POR]  = !power_on_reset_n;
    // R4 external hard
    src[SRC_HARD] = !hard_reset_n_i && !s_reg.hrst_oe;
    // R6 R7 external soft gated
    src[SRC_SOFT] = !soft_reset_n_i && !s_reg.srst_oe && (s_reg.st == S_IDLE);
    // R9 watchdog event
    src[SRC_WDT]  = watchdog_zero && s_reg.wdt_en;
    // R10 bus monitor event
    src[SRC_BM]   = bus_monitor_zero && s_reg.bm_en;
    // R11 host command
    src[SRC_HOST] = host_reset_cmd;
    hard_req = src[SRC_HARD] | src[SRC_WDT] | src[SRC_BM];
    soft_req = src[SRC_SOFT] | src[SRC_HOST];
    // R14 bus config window
    sys_win = (s_reg.st != S_IDLE) && (s_reg.st != S_SRST);

    ctrl_rd = {20'h0, s_reg.pdiv, 6'h00, s_reg.bm_en, s_reg.wdt_en};
    stat_rd = {22'h0, s_reg.locked, s_reg.st != S_IDLE, 2'h0, s_reg.status};
    ctrl_w  = wmerge(ctrl_rd, s_reg.w_data, s_reg.w_strb);

    // ******************************************************************
    // AXI4-Lite write channel
    // ******************************************************************
    if (s_axil_awvalid && s_reg.awrdy)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = s_axil_awaddr;
    end
    if (s_axil_wvalid && s_reg.wrdy)
    begin
      s_next.w_full = 1'b1;
      s_next.w_data = s_axil_wdata;
      s_next.w_strb = s_axil_wstrb;
    end
    if (s_reg.bvalid && s_axil_bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = RESP_OKAY;
      case (s_reg.aw_addr)
        OFF_CTRL:
        begin
          s_next.wdt_en = ctrl_w[CTRL_WDT_EN];
          s_next.bm_en  = ctrl_w[CTRL_BM_EN];
          s_next.pdiv   = ctrl_w[CTRL_PDIV_LSB +: PDIV_W];
        end
        OFF_STATUS:
        begin
          s_next.status = s_reg.status & ~(s_reg.w_data[5:0] & {6{s_reg.w_strb[0]}});
        end
        OFF_CFG_SYS:
        begin
          // R14 system bus write
          if (sys_win)
          begin
            s_next.cfg_word = wmerge(s_reg.cfg_word, s_reg.w_data, s_reg.w_strb);
            s_next.cfg_wr   = 1'b1;
          end
        end
        OFF_CFG_DSI:
        begin
          // R13 slave port write
          if (sys_win && s_reg.por_flow)
          begin
            s_next.cfg_word = wmerge(s_reg.cfg_word, s_reg.w_data, s_reg.w_strb);
            s_next.cfg_wr   = 1'b1;
          end
        end
        OFF_STRAPS, OFF_CFG_ACT:
        begin
          s_next.bresp = RESP_OKAY;
        end
        default:
        begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_next.awrdy = !s_next.aw_full;
    s_next.wrdy  = !s_next.w_full;

    // ******************************************************************
    // AXI4-Lite read channel
    // ******************************************************************
    if (s_reg.rvalid && s_axil_rready)
    begin
      s_next.rvalid = 1'b0;
    end
    if (s_axil_arvalid && s_reg.arrdy)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      case (s_axil_araddr)
        OFF_CTRL:    s_next.rdata = ctrl_rd;
        // R12 status readback
        OFF_STATUS:  s_next.rdata = stat_rd;
        OFF_STRAPS:  s_next.rdata = {18'h0, s_reg.straps};
        OFF_CFG_SYS: s_next.rdata = s_reg.cfg_word;
        OFF_CFG_DSI: s_next.rdata = s_reg.cfg_word;
        OFF_CFG_ACT: s_next.rdata = s_reg.cfg_act;
        default:
        begin
          s_next.rdata = 32'h0;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    s_next.arrdy = !s_next.rvalid;

    // ******************************************************************
    // Reset flow sequencing
    // ******************************************************************
    case (s_reg.st)
      S_IDLE:
      begin
        s_next.por_flow = 1'b0;
      end
      S_POR:
      begin
        if (power_on_reset_n)
        begin
          // R19 R2 R13 strap capture
          s_next.straps = {clock_mode_bits, watchdog_enable_strap,
                           boot_select_bits, device_ident_bits,
                           slave_port_width_sel, slave_port_sync_sel,
                           cfg_master_slave_sel, reset_cfg_mode_sel};
          s_next.wdt_en = watchdog_enable_strap;
          s_next.st     = S_PORDLY;
          s_next.cnt    = '0;
        end
      end
      S_PORDLY:
      begin
        // R20 internal power-on delay
        if (in_tick)
        begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (at_last(s_reg.cnt, POR_DLY_CYC))
          begin
            s_next.st  = S_LOCK;
            s_next.cnt = '0;
          end
        end
      end
      S_LOCK:
      begin
        // R21 PLL lock wait
        if (pll_tick)
        begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (at_last(s_reg.cnt, PLL_LOCK_TICKS))
          begin
            s_next.locked = 1'b1;
            s_next.st     = S_HRST;
            s_next.cnt    = '0;
          end
        end
      end
      S_HRST:
      begin
        if (in_tick)
        begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (at_last(s_reg.cnt, SRST_REL_CYC))
          begin
            s_next.st = S_IDLE;
            // R5 R17 R18 apply configuration
            if (s_reg.straps[STRAP_MS])
            begin
              s_next.cfg_act = cfg_fetch_word;
            end
            else
            begin
              s_next.cfg_act = s_reg.cfg_wr ? s_reg.cfg_word : DEFAULT_CFG;
            end
          end
        end
      end
      S_SRST:
      begin
        // R8 soft flow keeps configuration
        if (in_tick)
        begin
          s_next.cnt = s_reg.cnt + 1'b1;
          if (at_last(s_reg.cnt, SOFT_HOLD_CYC))
          begin
            s_next.st = S_IDLE;
          end
        end
      end
      default:
      begin
        s_next.st = S_POR;
      end
    endcase

    // R24 flow priority
    if (src[SRC_POR])
    begin
      new_flow        = (s_reg.st != S_POR);
      // R1 R13 full reset and PLL
      s_next.st       = S_POR;
      s_next.por_flow = 1'b1;
      s_next.locked   = 1'b0;
    end
    else if (hard_req && (s_reg.st == S_IDLE || s_reg.st == S_SRST))
    begin
      new_flow  = 1'b1;
      s_next.st = S_HRST;
    end
    else if (soft_req && s_reg.st == S_IDLE)
    begin
      new_flow  = 1'b1;
      s_next.st = S_SRST;
    end

    if (new_flow)
    begin
      s_next.cnt    = '0;
      // R12 R24 record sources
      s_next.status = src;
      if (s_next.st != S_SRST)
      begin
        // R14 interface registers reset
        s_next.wdt_en = s_reg.straps[STRAP_WDT];
        s_next.bm_en  = 1'b0;
        s_next.pdiv   = PDIV_RST;
        s_next.cfg_wr = 1'b0;
      end
    end
    else
    begin
      s_next.status = s_next.status | src;
    end

    // ******************************************************************
    // Reset outputs, derived from the next flow state
    // ******************************************************************
    s_next.int_por = (s_next.st == S_POR) || (s_next.st == S_PORDLY);
    s_next.pll_rst = s_next.int_por;
    // R1 R14 R22 hard pin drive
    s_next.hrst_oe = s_next.int_por || (s_next.st == S_LOCK)
                   || (s_next.st == S_HRST && s_next.cnt < CNT_W'(HRST_REL_CYC));
    // R3 R15 R23 soft pin drive
    s_next.srst_oe = s_next.hrst_oe || (s_next.st == S_HRST)
                   || (s_next.st == S_SRST);
    s_next.drv_low = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg         <= '0;
      s_reg.st      <= S_POR;
      s_reg.pdiv    <= PDIV_RST;
      s_reg.int_por <= 1'b1;
      s_reg.pll_rst <= 1'b1;
      s_reg.hrst_oe <= 1'b1;
      s_reg.srst_oe <= 1'b1;
      s_reg.por_flow <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign s_axil_awready    = s_reg.awrdy;
  assign s_axil_wready     = s_reg.wrdy;
  assign s_axil_bvalid     = s_reg.bvalid;
  assign s_axil_bresp      = s_reg.bresp;
  assign s_axil_arready    = s_reg.arrdy;
  assign s_axil_rvalid     = s_reg.rvalid;
  assign s_axil_rdata      = s_reg.rdata;
  assign s_axil_rresp      = s_reg.rresp;
  assign hard_reset_n_o    = s_reg.drv_low;
  assign hard_reset_n_oe   = s_reg.hrst_oe;
  assign soft_reset_n_o    = s_reg.drv_low;
  assign soft_reset_n_oe   = s_reg.srst_oe;
  assign internal_por      = s_reg.int_por;
  assign system_pll_reset  = s_reg.pll_rst;
  assign system_pll_locked = s_reg.locked;
  assign sysif_reset       = s_reg.hrst_oe;
  // R15 all sources
  assign periph_bus_reset  = s_reg.srst_oe;
  assign core_reset        = s_reg.srst_oe;
  assign shared_bus_reset  = s_reg.srst_oe;
  assign active_cfg_word   = s_reg.cfg_act;
  assign strap_word        = s_reg.straps;

endmodule // mrc_reset_ctrl

/* tb/mrc_reset_monitor.sv */
/*
  Port checker for the reset controller, bound to mrc_reset_ctrl.
  Assumes one aclk domain and the lock parameter handed on by the bind.
*/
`timescale 1ns/1ps
module mrc_reset_monitor
#(
  parameter int PLL_LOCK_TICKS = 8
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        hard_reset_n_i,
  input wire logic        hard_reset_n_o,
  input wire logic        hard_reset_n_oe,
  input wire logic        soft_reset_n_i,
  input wire logic        soft_reset_n_o,
  input wire logic        soft_reset_n_oe,
  input wire logic        internal_por,
  input wire logic        system_pll_reset,
  input wire logic        system_pll_locked,
  input wire logic        sysif_reset,
  input wire logic        periph_bus_reset,
  input wire logic        core_reset,
  input wire logic        shared_bus_reset,
  input wire logic [13:0] strap_word
);
  // ****
  // Lock time bound and cycles of hard pin drive with the PLL locked
  // ****
  localparam int LOCK_MAX = PLL_LOCK_TICKS * 32 + 8;
  logic [10:0] rel_cnt;
  always_ff @(posedge aclk)
    rel_cnt <= (!aresetn || !hard_reset_n_oe || !system_pll_locked) ? 11'h0 : rel_cnt + 11'h1;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ****
  // Assertions
  // ****
  pins_od_a: assert property (!hard_reset_n_o && !soft_reset_n_o)
    else $error("reset pin output not low");
  hard_soft_a: assert property (hard_reset_n_oe |-> soft_reset_n_oe)
    else $error("hard pin driven without soft pin");
  por_scope_a: assert property (internal_por |-> system_pll_reset && hard_reset_n_oe
    && soft_reset_n_oe && sysif_reset && core_reset && periph_bus_reset && shared_bus_reset)
    else $error("power-on reset incomplete");
  pll_por_a: assert property (system_pll_reset == internal_por)
    else $error("pll reset outside power-on");
  lock_delay_a: assert property ($fell(internal_por) |->
    !system_pll_locked [*8] ##[1:LOCK_MAX] system_pll_locked) else $error("lock time wrong");
  hard_rel_a: assert property ($fell(hard_reset_n_oe) && system_pll_locked |->
    rel_cnt >= 11'd1018 && rel_cnt <= 11'd1030) else $error("hard release time wrong");
  soft_rel_a: assert property ($fell(hard_reset_n_oe) |->
    soft_reset_n_oe [*4] ##[1:4] !soft_reset_n_oe) else $error("soft release time wrong");
  ext_hard_a: assert property (!hard_reset_n_i && !hard_reset_n_oe |=> hard_reset_n_oe)
    else $error("external hard request ignored");
  ext_soft_a: assert property (!soft_reset_n_i && !soft_reset_n_oe |=> soft_reset_n_oe)
    else $error("external soft request ignored");
  soft_scope_a: assert property ($rose(soft_reset_n_oe) && !hard_reset_n_oe |->
    core_reset && periph_bus_reset && shared_bus_reset && !sysif_reset)
    else $error("soft flow scope wrong");
  strap_hold_a: assert property (!internal_por && !$past(internal_por) |->
    $stable(strap_word)) else $error("straps changed outside power-on");
endmodule // mrc_reset_monitor

bind mrc_reset_ctrl mrc_reset_monitor #(.PLL_LOCK_TICKS(PLL_LOCK_TICKS)) mon_u (.*);

/* tb/mrc_board_model.sv */
/*
  Board reset supervisor: power-on pin with minimum hold, pulled-up wires.
  Assumes requests from the bench, synchronous to aclk.
*/
`timescale 1ns/1ps
module mrc_board_model
(
  input wire logic aclk,
  input wire logic por_req,
  input wire logic hard_pull,
  input wire logic soft_pull,
  input wire logic hard_oe,
  input wire logic soft_oe,
  output logic     power_on_reset_n = 1'b0,
  output logic     hard_wire,
  output logic     soft_wire
);
  logic [5:0] hold_cnt = 6'h0;

  always @(posedge aclk)
  begin
    hold_cnt <= por_req ? 6'h0 : (hold_cnt == 6'h28 ? hold_cnt : hold_cnt + 6'h1);
    power_on_reset_n <= !por_req && hold_cnt == 6'h28;
  end

  // Pull-ups win when nobody pulls low
  assign hard_wire = !(hard_oe || hard_pull);
  assign soft_wire = !(soft_oe || soft_pull);
endmodule // mrc_board_model

/* tb/tb_top.sv */
/*
  Self-checking bench for the reset controller beside a board model.
  Assumes the design package and a 200 MHz aclk made here.
*/
`timescale 1ns/1ps
module tb_top
  import mrc_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn, por_req, power_on_reset_n, hard_reset_n_i, soft_reset_n_i;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic        s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready;
  logic        s_axil_rvalid, s_axil_rready, hard_reset_n_o, hard_reset_n_oe;
  logic        soft_reset_n_o, soft_reset_n_oe, internal_por, system_pll_reset;
  logic        system_pll_locked, sysif_reset, periph_bus_reset, core_reset, shared_bus_reset;
  logic [7:0]  s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata, cfg_fetch_word, active_cfg_word, cw;
  logic [1:0]  s_axil_bresp, s_axil_rresp;
  logic [3:0]  s_axil_wstrb = 4'hf;
  logic [13:0] strap_word, st, sw;
  logic [4:0]  req;
  logic [4:0]  src_tab [6] = '{5'h01, 5'h04, 5'h08, 5'h02, 5'h10, 5'h14};
  int          fail_count = 0;
  int          checks = 0;
  int          cyc = 0;

  always #2.5 aclk = ~aclk;

  mrc_reset_ctrl #(.PLL_LOCK_TICKS(8)) dut_u (.watchdog_zero(req[2]),
    .bus_monitor_zero(req[3]), .host_reset_cmd(req[4]), .reset_cfg_mode_sel(st[0]),
    .cfg_master_slave_sel(st[1]), .slave_port_sync_sel(st[2]), .slave_port_width_sel(st[3]),
    .device_ident_bits(st[7:4]), .boot_select_bits(st[10:8]),
    .watchdog_enable_strap(st[11]), .clock_mode_bits(st[13:12]), .*);

  mrc_board_model board_u (.aclk, .por_req, .hard_pull(req[0]), .soft_pull(req[1]),
    .hard_oe(hard_reset_n_oe), .soft_oe(soft_reset_n_oe), .power_on_reset_n,
    .hard_wire(hard_reset_n_i), .soft_wire(soft_reset_n_i));

  // ****
  // Checking and closing
  // ****
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] exp_cfg(input logic ms, input logic [31:0] wr,
                                          input logic [31:0] fe);
    return ms ? fe : wr;
  endfunction

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      fail_count++;
      stop_test();
    end
  end

  // ****
  // Bus and flow tasks
  // ****
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    r = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    d = s_axil_rdata;
    r = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  task automatic wait_idle;
    do @(posedge aclk); while (hard_reset_n_oe || soft_reset_n_oe || internal_por);
  endtask

  task automatic por(input logic ms);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    st <= (14'($urandom) & 14'h3ffd) | {12'h0, ms, 1'b0};
    por_req <= 1'b1;
    repeat (50) @(posedge aclk);
    sw = st;
    por_req <= 1'b0;
    n = 0;
    do @(posedge aclk); while (!power_on_reset_n);
    st <= ~st;
    do
    begin
      @(posedge aclk);
      n++;
    end while (internal_por);
    chk(32'(n >= 2044 && n <= 2054), 32'h1);
    wait_idle();
    cw = exp_cfg(ms, DEFAULT_CFG, cfg_fetch_word);
    chk(strap_word, sw);
    chk(active_cfg_word, cw);
    axr(OFF_STATUS, d, r);
    chk(d & 32'h3ff, 32'h201);
  endtask

  task automatic flow(input logic [4:0] m, input logic hard);
    logic [31:0] d;
    logic [31:0] w;
    logic [1:0]  r;
    w = $urandom;
    axw(OFF_CTRL, 32'h103, r);
    req <= m;
    repeat (4) @(posedge aclk);
    req <= 5'h0;
    chk(hard_reset_n_oe, hard);
    chk(soft_reset_n_oe, 1'b1);
    axw(OFF_CFG_SYS, w, r);
    axw(OFF_CFG_DSI, ~w, r);
    st <= 14'($urandom);
    if (hard)
      cw = w;
    wait_idle();
    axr(OFF_STATUS, d, r);
    chk(d & 32'h3f, {26'h0, m, 1'b0});
    chk(active_cfg_word, cw);
    chk(strap_word, sw);
  endtask

  // ****
  // Main sequence
  // ****
  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    void'($urandom(32'h638d0bf0));
    {aresetn, s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
    {s_axil_arvalid, s_axil_rready, s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    req = 5'h0;
    por_req = 1'b1;
    st = 14'h0;
    cfg_fetch_word = $urandom;
    cw = DEFAULT_CFG;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por(1'b0);
    axr(OFF_CTRL, d, r);
    chk((d >> 8) & 32'hf, 32'(PDIV_RST));
    axw(OFF_STRAPS, $urandom, r);
    chk(r, RESP_OKAY);
    axr(OFF_STRAPS, d, r);
    chk(d, 32'(sw));
    axw(8'h44, 32'h0, r);
    chk(r, RESP_SLVERR);
    axr(8'h40, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0);
    axw(OFF_STATUS, 32'h3f, r);
    axr(OFF_STATUS, d, r);
    chk(d & 32'h3f, 32'h0);
    axw(OFF_CTRL, 32'h100, r);
    req <= 5'h0c;
    repeat (8) @(posedge aclk);
    req <= 5'h0;
    chk(hard_reset_n_oe, 1'b0);
    foreach (src_tab[i])
      flow(src_tab[i], i < 3 || i == 5);
    por(1'b1);
    stop_test();
  end
endmodule // tb_top
